//--- bench/bus_master.sv
// Behavioural two-wire bus master that drives the serial clock.
// Assumes a pull-up on the data line; sda is the resolved wire level.
`timescale 1ns/1ps
module bus_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Quarter bit time: clock low and high each last two of these
  localparam int QTR = 300;

  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data falls while the clock is high
  task automatic start();
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // Data rises while the clock is high; clock then stands still
  task automatic stop();
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #(4 * QTR);
  endtask

  // One bit: data moves only mid-low, sampled mid-way through the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // Byte out, MSB first, then the device's acknowledge bit
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask

  // Byte in, then our own acknowledge (1 ends the read)
  task automatic read_byte(input logic ack_bit, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(ack_bit, r);
  endtask

  // Bus recovery: nine released clocks, then a start
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) bit_io(1'b1, r);
    start();
  endtask
endmodule

//--- bench/twowire_mem_slave_test.sv
// Self-checking bench for the two-wire memory slave.
// Assumes the bus master model drives both serial clock inputs.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module twowire_mem_slave_test;
  import twowire_mem_pkg::*;
  localparam int WCYC = 600; // Programming cycle, longer than one poll
  typedef struct packed {logic [7:0] wa; logic [7:0] dat;} row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sel = 3'h5; // Strapped select levels
  logic wp = 1'b0; // Write protect
  logic scl, pull, sda, sda_out, sda_oe, standby, write_busy;
  int n_fail = 0;
  int n_tests = 0;
  logic [7:0] q;
  logic [7:0] exp_pg [8]; // Expected page after wrap-around write
  row_t rows [4] = '{'{8'h00, 8'h3c}, '{8'hff, 8'ha5},
                     '{8'h57, 8'h00}, '{8'h80, 8'hff}};

  // Open-drain wire with pull-up
  assign sda = (sda_oe | pull) ? 1'b0 : 1'b1;
  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  twowire_mem_slave #(.WRITE_CYCLE_COUNT(WCYC)) twowire_mem_slave_i (
    .mclk(mclk), .rstn(rstn), .serial_clk(scl), .scl_in(scl),
    .sda_in(sda), .device_select_pins(sel), .write_protect(wp),
    .sda_out(sda_out), .sda_oe(sda_oe), .standby(standby),
    .write_busy(write_busy));
  bus_master bus_master_i (.scl(scl), .sda_pull(pull), .sda(sda));

  // Send one word and check the acknowledge bit
  task automatic word(input logic [7:0] w, input logic e);
    logic r;
    bus_master_i.write_byte(w, r);
    `CHK(r, e)
  endtask
  // Start, write address word, word address
  task automatic wr_start(input logic [7:0] wa);
    bus_master_i.start();
    word({DEV_TYPE_CODE, sel, 1'b0}, 1'b0);
    word(wa, 1'b0);
  endtask
  // Stop a write, poll while busy, wait for the cycle to end
  task automatic finish_write(input logic busy_exp);
    bus_master_i.stop();
    repeat (10) @(negedge mclk);
    `CHK(write_busy, busy_exp)
    `CHK(standby, ~busy_exp)
    if (busy_exp) begin
      bus_master_i.start();
      word({DEV_TYPE_CODE, sel, 1'b0}, 1'b1);
      bus_master_i.stop();
      for (int i = 0; i < WCYC && write_busy; i++) @(negedge mclk);
      repeat (3) @(negedge mclk);
      `CHK(standby, 1'b1)
    end
  endtask
  // Random read of one byte, then standby after the stop
  task automatic rd(input logic [7:0] wa, output logic [7:0] d);
    wr_start(wa);
    bus_master_i.start();
    word({DEV_TYPE_CODE, sel, 1'b1}, 1'b0);
    bus_master_i.read_byte(1'b1, d);
    bus_master_i.stop();
    repeat (8) @(negedge mclk);
    `CHK(standby, 1'b1)
  endtask

  // Print the counts and the verdict, then end the run
  task automatic test_done();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge mclk);
    `CHK(standby, 1'b1)
    `CHK(sda_oe, 1'b0)
    repeat (1) @(negedge mclk);
    rstn = 1'b1;
    repeat (5) @(negedge mclk);
    bus_master_i.recover();
    bus_master_i.stop();
    // Table: byte write, polled cycle, random read back
    foreach (rows[i]) begin
      wr_start(rows[i].wa);
      word(rows[i].dat, 1'b0);
      finish_write(1'b1);
      rd(rows[i].wa, q);
      `CHK(q, rows[i].dat)
    end
    // Wrong select bits and wrong type code are ignored
    bus_master_i.start();
    word({DEV_TYPE_CODE, 3'h4, 1'b0}, 1'b1);
    bus_master_i.start();
    word({4'hb, sel, 1'b1}, 1'b1);
    bus_master_i.stop();
    // Ten bytes into one page from 0x1e wrap onto its start
    wr_start(8'h1e);
    for (int i = 0; i < 10; i++) begin
      word(8'h40 + 8'(i), 1'b0);
      exp_pg[(6 + i) % 8] = 8'h40 + 8'(i);
    end
    finish_write(1'b1);
    // Current read continues at page start, sequential over page
    bus_master_i.start();
    word({DEV_TYPE_CODE, sel, 1'b1}, 1'b0);
    for (int k = 0; k < 8; k++) begin
      bus_master_i.read_byte(k == 7, q);
      `CHK(q, exp_pg[k])
    end
    bus_master_i.stop();
    // Sequential read wraps from the last byte to the first
    wr_start(8'hff);
    bus_master_i.start();
    word({DEV_TYPE_CODE, sel, 1'b1}, 1'b0);
    bus_master_i.read_byte(1'b0, q);
    `CHK(q, 8'ha5)
    bus_master_i.read_byte(1'b1, q);
    `CHK(q, 8'h3c)
    bus_master_i.stop();
    // Protected write: acknowledged but not programmed
    @(negedge mclk) wp = 1'b1;
    wr_start(8'h57);
    word(8'h99, 1'b0);
    finish_write(1'b0);
    @(negedge mclk) wp = 1'b0;
    rd(8'h57, q);
    `CHK(q, 8'h00)
    // Mid-run reset: status idles, counter returns to zero, array kept;
    // the select straps move while reset is held
    @(negedge mclk) rstn = 1'b0;
    sel = 3'h2;
    repeat (4) @(negedge mclk);
    `CHK(standby, 1'b1)
    `CHK(write_busy, 1'b0)
    `CHK(sda_oe, 1'b0)
    rstn = 1'b1;
    repeat (8) @(negedge mclk);
    bus_master_i.start();
    word({DEV_TYPE_CODE, 3'h5, 1'b1}, 1'b1);
    bus_master_i.start();
    word({DEV_TYPE_CODE, sel, 1'b1}, 1'b0);
    bus_master_i.read_byte(1'b1, q);
    bus_master_i.stop();
    `CHK(q, 8'h3c)
    `CHK(sda_out, 1'b0)
    test_done();
  end
endmodule

//--- verilog/pin_sync3.sv
// Three-stage synchroniser for levels entering the system clock domain.
// Assumes inputs change slowly against the clock; the output follows once
// the second and third stages agree.
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1; // First stage, read only by s2
  logic [WIDTH-1:0] s2; // Second stage
  logic [WIDTH-1:0] s3; // Third stage

  // Shift chain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= INIT;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end

endmodule

//--- verilog/twowire_mem_pkg.sv
// Shared constants and types for the two-wire serial memory slave.
// Assumes a 40 MHz system clock and a bus master on a separate serial clock.
package twowire_mem_pkg;

  // Array geometry: 32 pages of 8 bytes, one 8-bit word address
  localparam int ADDR_W = 8;
  localparam int MEM_WORDS = 256;
  localparam int PAGE_BYTES = 8;
  localparam int PAGE_IDX_W = 3;

  // Fixed upper nibble of the device address word
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;

  // Last bit index of a serial word
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [1:0] PINS_IDLE = 2'h3;
  localparam logic [3:0] STRAPS_RESET = 4'h0;

  // Self-timed programming cycle, longest time rounds down
  localparam int MCLK_KHZ = 40000;
  localparam int WRITE_CYCLE_TIME_US = 5000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_US * MCLK_KHZ / 1000;
  localparam int WC_W = 24;

  // Bus pins after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } pin_t;

  // Strapped pins after synchronisation
  typedef struct packed {
    logic [2:0] device_select_pins;
    logic wp;
  } strap_t;

  // Protocol engine states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DEVADDR  = 3'b001,
    ST_ACK      = 3'b010,
    ST_WORDADDR = 3'b011,
    ST_DATA     = 3'b100,
    ST_TX       = 3'b101,
    ST_MACK     = 3'b110
  } state_t;

endpackage

//--- verilog/twowire_mem_slave.sv
// Two-wire serial slave with a 256 x 8 array, page writes and reads.
// Assumes an external pull-up on the data line, a master that drives the
// serial clock, and the serial clock wired to both serial_clk and scl_in.
//
// Overview of operation
// - Data changes only while clock low
// - Falling data, clock high: start condition
// - Rising data, clock high: stop, then standby
// - Acknowledge every received byte on ninth clock
// - Standby at power-up and after stop
// - Address word: 1010 then select pins
// - Address bit zero selects read or write
// - Match acknowledges; mismatch returns to standby
// - Byte write: address, word address, data, stop
// - Stop after write starts silent programming cycle
// - Page write takes up to eight bytes
// - Write address wraps within its page
// - Acknowledge polling answered only when idle
// - Address counter holds last address plus one
// - Read address wraps over whole array
// - Current read sends byte at counter
// - Sequential read continues while master acknowledges
// - Sample on rising clock, drive after falling
// - Write protect pin high blocks all writes
// - Array is 32 pages of 8 bytes
`timescale 1ns/1ps
module twowire_mem_slave
  import twowire_mem_pkg::*;
#(
  parameter int WRITE_CYCLE_COUNT = WRITE_CYCLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [2:0] device_select_pins,
  input wire logic write_protect,
  output logic sda_out,
  output logic sda_oe,
  output logic standby,
  output logic write_busy
);

  // Last count of the programming timer
  localparam logic [WC_W-1:0] WC_LAST = WC_W'(WRITE_CYCLE_COUNT - 1);

  // Link domain: bit captured on the rising serial clock
  logic rx_bit = 1'b0;
  // Link domain: toggles once per rising serial clock
  logic rise_tgl = 1'b0;

  // Capture the data line on each rising serial clock
  always_ff @(posedge serial_clk) begin
    rx_bit <= sda_in;
  end

  // Flag each captured bit by a toggle for the system domain
  always_ff @(posedge serial_clk) begin
    rise_tgl <= ~rise_tgl;
  end

  pin_t pins_raw; // Bus pins before synchronising
  pin_t pins_s; // Bus pins after synchronising
  strap_t straps_raw; // Straps before synchronising
  strap_t straps_s; // Straps after synchronising
  logic tgl_s; // Synchronised rise toggle
  logic tgl_seen; // Toggle value already handled
  pin_t pins_prev; // Pins one cycle earlier

  assign pins_raw = '{scl: scl_in, sda: sda_in};
  assign straps_raw = '{device_select_pins: device_select_pins,
                        wp: write_protect};

  // Bus pins into the system domain
  pin_sync3 #(.WIDTH(2), .INIT(PINS_IDLE)) u_pin_sync (
    .clk(mclk),
    .rstn(rstn),
    .d(pins_raw),
    .q(pins_s)
  );

  // Strapped pins into the system domain
  pin_sync3 #(.WIDTH(4), .INIT(STRAPS_RESET)) u_strap_sync (
    .clk(mclk),
    .rstn(rstn),
    .d(straps_raw),
    .q(straps_s)
  );

  // Bit toggle into the system domain
  pin_sync3 #(.WIDTH(1), .INIT(1'b0)) u_tgl_sync (
    .clk(mclk),
    .rstn(rstn),
    .d(rise_tgl),
    .q(tgl_s)
  );

  // Edge history of pins and toggle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pins_prev <= PINS_IDLE;
      tgl_seen <= 1'b0;
    end else begin
      pins_prev <= pins_s;
      tgl_seen <= tgl_s;
    end
  end

  state_t state; // Protocol engine state
  state_t ack_next; // State after the acknowledge slot
  logic [2:0] bit_cnt; // Bits seen in the current word
  logic [7:0] shift; // Received word
  logic ack_drv; // Acknowledge currently driven
  logic [7:0] tx_shift; // Word being sent
  logic [7:0] addr; // Word address counter
  logic [7:0] page_buf [0:PAGE_BYTES-1]; // Pending page data
  logic [PAGE_BYTES-1:0] page_valid; // Pending page bytes
  logic [7:0] mem [0:MEM_WORDS-1]; // The array
  logic busy; // Programming cycle running
  logic [WC_W-1:0] wc_count; // Programming cycle timer

  logic bit_ev; // A bit was captured
  logic scl_fall; // Serial clock fell
  logic start_det; // Start seen
  logic stop_det; // Stop seen
  logic active; // Engine may advance this cycle
  logic [7:0] next_shift; // Word with the new bit
  logic dev_match; // Address word selects this device
  logic word_done; // Last bit of a received word
  logic wa_done; // Word address received
  logic data_done; // Data byte received
  logic tx_load; // Fetch and send a new byte
  logic tx_next; // Send the next bit of the byte
  logic commit; // Start programming the page

  // Event decode from the synchronised pins
  always_comb begin
    bit_ev = tgl_s ^ tgl_seen;
    scl_fall = pins_prev.scl & ~pins_s.scl;
    // Data moving while the clock is high is never data
    start_det = pins_s.scl & pins_prev.scl &
                pins_prev.sda & ~pins_s.sda;
    stop_det = pins_s.scl & pins_prev.scl &
               ~pins_prev.sda & pins_s.sda;
    active = ~busy & ~start_det & ~stop_det;
    next_shift = {shift[6:0], rx_bit};
    dev_match = next_shift[7:1] == {DEV_TYPE_CODE,
                                    straps_s.device_select_pins};
    word_done = active & bit_ev & (bit_cnt == LAST_BIT);
    wa_done = word_done & (state == ST_WORDADDR);
    data_done = word_done & (state == ST_DATA);
    tx_load = active & scl_fall &
              (((state == ST_TX) & (bit_cnt == 3'h0)) |
               ((state == ST_ACK) & ack_drv & (ack_next == ST_TX)));
    tx_next = active & scl_fall & (state == ST_TX) & (bit_cnt != 3'h0);
    commit = stop_det & ~busy & (|page_valid) & ~straps_s.wp;
  end

  // Protocol engine
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      ack_next <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      ack_drv <= 1'b0;
    end else if (busy) begin
      // Inputs ignored while programming
      state <= ST_IDLE;
      ack_drv <= 1'b0;
    end else if (start_det) begin
      // Start is honoured in any state
      state <= ST_DEVADDR;
      bit_cnt <= 3'h0;
      ack_drv <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      ack_drv <= 1'b0;
    end else begin
      case (state)
        ST_DEVADDR, ST_WORDADDR, ST_DATA: begin
          // Receive a word, MSB first
          if (bit_ev) begin
            shift <= next_shift;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              state <= ST_ACK;
              if (state == ST_DEVADDR) begin
                if (!dev_match) begin
                  state <= ST_IDLE;
                end
                // Direction bit picks read or write
                ack_next <= next_shift[0] ? ST_TX : ST_WORDADDR;
              end else begin
                ack_next <= ST_DATA;
              end
            end
          end
        end
        ST_ACK: begin
          // Hold the line low for the whole ninth clock
          if (scl_fall) begin
            ack_drv <= ~ack_drv;
            if (ack_drv) begin
              state <= ack_next;
            end
          end
        end
        ST_TX: begin
          // Count bits sampled by the master
          if (bit_ev) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              state <= ST_MACK;
            end
          end
        end
        ST_MACK: begin
          // Master acknowledge continues, no acknowledge ends
          if (bit_ev) begin
            state <= rx_bit ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Data line driver, only ever pulls low
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sda_oe <= 1'b0;
      tx_shift <= 8'h00;
    end else if (!active) begin
      sda_oe <= 1'b0;
    end else if (tx_load) begin
      tx_shift <= mem[addr];
      sda_oe <= ~mem[addr][7];
    end else if (tx_next) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
      sda_oe <= ~tx_shift[6];
    end else if (scl_fall) begin
      // Acknowledge slot opens on the first fall
      sda_oe <= (state == ST_ACK) & ~ack_drv;
    end
  end

  // Line level while driven
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0;
  end

  // Word address counter
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr <= ADDR_RESET;
    end else if (wa_done) begin
      addr <= next_shift;
    end else if (data_done) begin
      // Only the in-page bits advance on writes
      addr <= {addr[7:3], addr[2:0] + 3'h1};
    end else if (tx_load) begin
      // Whole-array wrap on reads
      addr <= addr + 8'h01;
    end
  end

  // Page buffer collecting write data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      page_valid <= '0;
    end else if ((start_det || stop_det) && !busy) begin
      // A start aborts, a stop commits or discards
      page_valid <= '0;
    end else if (data_done) begin
      page_buf[addr[2:0]] <= next_shift;
      page_valid[addr[2:0]] <= 1'b1;
    end
  end

  // Array update when programming begins
  always_ff @(posedge mclk) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commit && page_valid[i]) begin
        mem[{addr[7:3], PAGE_IDX_W'(i)}] <= page_buf[i];
      end
    end
  end

  // Self-timed programming cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      busy <= 1'b0;
      wc_count <= '0;
    end else if (commit) begin
      busy <= 1'b1;
      wc_count <= '0;
    end else if (busy) begin
      wc_count <= wc_count + 1'b1;
      if (wc_count == WC_LAST) begin
        busy <= 1'b0;
      end
    end
  end

  // Status outputs
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      standby <= 1'b1;
      write_busy <= 1'b0;
    end else begin
      standby <= (state == ST_IDLE) & ~busy;
      write_busy <= busy;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  chk_ack_slot: assert property (
    (active && state == ST_ACK && scl_fall && !ack_drv)
    |=> sda_oe ##1 (state == ST_ACK && ack_drv))
    else $error("acknowledge not driven");
  chk_start_addr: assert property (
    (start_det && !busy) |=> (state == ST_DEVADDR && bit_cnt == 3'h0))
    else $error("start not honoured");
  chk_stop_idle: assert property (
    (stop_det && !busy && page_valid == '0)
    |=> (state == ST_IDLE) ##1 standby)
    else $error("no standby after stop");
  chk_addr_mismatch: assert property (
    (state == ST_DEVADDR && word_done && !dev_match)
    |=> (state == ST_IDLE) ##1 !sda_oe)
    else $error("mismatched address answered");
  chk_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("driving while programming");
  chk_busy_min: assert property ($rose(busy) |=> busy[*8])
    else $error("programming cycle cut short");
  chk_busy_end: assert property (
    (busy && wc_count == WC_LAST) |=> !busy)
    else $error("programming cycle overruns");
  chk_wp_block: assert property (
    (stop_det && !busy && straps_s.wp) |=> !busy)
    else $error("write while protected");
  chk_page_wrap: assert property (
    (data_done && addr[2:0] == 3'h7)
    |=> (addr[2:0] == 3'h0 && addr[7:3] == $past(addr[7:3])))
    else $error("page wrap wrong");
  chk_read_wrap: assert property (
    (tx_load && addr == 8'hff) |=> (addr == 8'h00))
    else $error("read wrap wrong");
  chk_drive_fall: assert property (
    $rose(sda_oe) |-> $past(scl_fall))
    else $error("drive not after falling clock");

  cov_page_commit: cover property (commit && page_valid == 8'hff);
  cov_read_load: cover property (tx_load ##[1:1000] tx_load);
  cov_master_nack: cover property (state == ST_MACK && bit_ev && rx_bit);
  cov_mismatch: cover property (
    state == ST_DEVADDR && word_done && !dev_match);

endmodule
